// ===== rtl/bcdalu_pkg.sv
// Shared constants and types of the BCD and real subtract/multiply unit
package bcdalu_pkg;
    localparam int DATA_W   = 32;
    localparam int ADDR_W   = 4;
    localparam int DIG_W    = 4;
    localparam int DIGITS   = 8;
    localparam int EXP_W    = 8;
    localparam int MAN_W    = 23;

    localparam logic [3:0] DIG_RADIX = 4'hA;
    localparam logic [3:0] DIG_MAX   = 4'h9;

    localparam logic [ADDR_W-1:0] OFS_ACC   = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_FLAGS = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_STAT  = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_MASK  = 4'hC;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam logic [EXP_W-1:0] EXP_MAX  = 8'hFF;
    localparam logic [31:0]      REAL_NAN = 32'h7FC00000;
    localparam logic [31:0]      ACC_RST  = 32'h00000000;

    typedef enum logic [2:0] {
        OP_LOAD  = 3'h0,
        OP_SUB16 = 3'h1,
        OP_SUB32 = 3'h3,
        OP_REAL_MINUS  = 3'h2,
        OP_MUL16 = 3'h6
    } bcdalu_op_t;

    typedef struct packed {
        logic        valid;
        bcdalu_op_t  op;
        logic [31:0] operand;
        logic        ptr_bad;
    } bcdalu_req_t;

    typedef struct packed {
        logic bad_bcd;
        logic underflow;
        logic sign_error;
        logic bad_float;
        logic bad_pointer;
        logic negative;
        logic borrow_32;
        logic borrow_16;
        logic zero_result;
    } bcdalu_flags_t;

    typedef struct packed {
        logic          done;
        bcdalu_flags_t flags;
    } bcdalu_irq_t;

    typedef struct packed {
        logic [31:0]       acc;
        bcdalu_flags_t     flags;
        logic              done;
        bcdalu_irq_t       stat;
        bcdalu_irq_t       mask;
        logic              irq;
        logic              awready;
        logic              wready;
        logic              aw_got;
        logic              w_got;
        logic [ADDR_W-1:0] waddr;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
    } bcdalu_state_t;
endpackage

// ===== rtl/bcdalu_bcd_unit.sv
// Per-digit BCD subtractor and four-digit BCD multiplier
module bcdalu_bcd_unit #(
    parameter int DIGITS = bcdalu_pkg::DIGITS
) (
    input  wire logic [DIGITS*4-1:0] a,
    input  wire logic [DIGITS*4-1:0] b,
    output logic      [DIGITS*4-1:0] diff,
    output logic      [DIGITS:0]     brw,
    output logic      [DIGITS*4-1:0] prod,
    output logic      [DIGITS-1:0]   a_bad,
    output logic      [DIGITS-1:0]   b_bad
);
    localparam int W  = bcdalu_pkg::DIG_W;
    localparam int PW = DIGITS * W;

    function automatic logic [13:0] bcd4_to_bin(input logic [15:0] v);
        logic [13:0] acc;
        acc = '0;
        for (int i = 3; i >= 0; i--) begin
            acc = 14'(acc * 14'd10 + 14'(v[i*W+:W]));
        end
        return acc;
    endfunction

    // Double dabble; a full product of two 4-digit values fits 27 bits
    function automatic logic [31:0] bin_to_bcd8(input logic [26:0] v);
        logic [31:0] r;
        r = '0;
        for (int i = 26; i >= 0; i--) begin
            for (int d = 0; d < 8; d++) begin
                if (r[d*W+:W] > 4'h4) begin
                    r[d*W+:W] = r[d*W+:W] + 4'h3;
                end
            end
            r = {r[30:0], v[i]};
        end
        return r;
    endfunction

    assign brw[0] = 1'b0;

    for (genvar g = 0; g < DIGITS; g++) begin : g_dig
        logic [W:0] d;
        assign d = {1'b0, a[g*W+:W]} - {1'b0, b[g*W+:W]}
                   - {{W{1'b0}}, brw[g]};
        assign brw[g+1] = d[W];
        assign diff[g*W+:W] = d[W] ? d[W-1:0] + bcdalu_pkg::DIG_RADIX
                                   : d[W-1:0];
        assign a_bad[g] = a[g*W+:W] > bcdalu_pkg::DIG_MAX;
        assign b_bad[g] = b[g*W+:W] > bcdalu_pkg::DIG_MAX;
    end

    // 9999 x 9999 stays below 2**27, so no product bit is lost
    logic [26:0] bin_prod;
    assign bin_prod = 27'(bcd4_to_bin(a[15:0])) * 27'(bcd4_to_bin(b[15:0]));
    assign prod = PW'(bin_to_bcd8(bin_prod));
endmodule

// ===== rtl/bcdalu_fsub.sv
// Single-precision real subtractor, truncating, denormals flushed
module bcdalu_fsub (
    input  wire logic [31:0] a,
    input  wire logic [31:0] b,
    output logic      [31:0] res,
    output logic             bad_float,
    output logic             underflow,
    output logic             overflow
);
    localparam int EW = bcdalu_pkg::EXP_W;
    localparam int MW = bcdalu_pkg::MAN_W;

    logic        sa;
    logic        sb;
    logic [7:0]  ea;
    logic [7:0]  eb;
    logic [26:0] ma;
    logic [26:0] mb;
    logic [27:0] sum;
    logic [9:0]  ex;
    logic [4:0]  lz;
    logic [7:0]  sh;

    always_comb begin
        res = '0;
        bad_float = 1'b0;
        underflow = 1'b0;
        overflow = 1'b0;
        lz = '0;
        sa = a[31];
        sb = ~b[31];
        ea = a[30:MW];
        eb = b[30:MW];
        ma = (ea == '0) ? '0 : {1'b1, a[MW-1:0], 3'h0};
        mb = (eb == '0) ? '0 : {1'b1, b[MW-1:0], 3'h0};
        if (b[30:0] > a[30:0]) begin
            {sa, ea, ma, sb, eb, mb} = {sb, eb, mb, sa, ea, ma};
        end
        sh = ea - eb;
        mb = (sh > 8'd26) ? '0 : mb >> sh;
        sum = (sa == sb) ? {1'b0, ma} + {1'b0, mb}
                         : {1'b0, ma} - {1'b0, mb};
        ex = {2'b00, ea};
        if (sum[27]) begin
            sum = sum >> 1;
            ex = ex + 10'd1;
        end else begin
            for (int i = 0; i < 27; i++) begin
                if (sum[i]) begin
                    lz = 5'(26 - i);
                end
            end
            sum = sum << lz;
            ex = ex - {5'b0, lz};
        end
        if (ea == bcdalu_pkg::EXP_MAX || eb == bcdalu_pkg::EXP_MAX) begin
            res = bcdalu_pkg::REAL_NAN;
            bad_float = 1'b1;
        end else if (sum == '0) begin
            res = '0;
        end else if ($signed(ex) >= $signed({2'b00, bcdalu_pkg::EXP_MAX})) begin
            res = {sa, bcdalu_pkg::EXP_MAX, {MW{1'b0}}};
            overflow = 1'b1;
            bad_float = 1'b1;
        end else if ($signed(ex) <= 0) begin
            res = '0;
            underflow = 1'b1;
        end else begin
            res = {sa, ex[EW-1:0], sum[25:3]};
        end
    end
endmodule

// ===== rtl/bcdalu_top.sv
// Accumulator arithmetic unit with AXI4-Lite status and interrupt registers
//
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
module bcdalu_top (
    input  wire logic                              clk_sys,
    input  wire logic                              rst_b,
    input  wire bcdalu_pkg::bcdalu_req_t           req,
    output logic                                   op_done,
    output logic [31:0]                            acc_out,
    output bcdalu_pkg::bcdalu_flags_t              flags_out,
    output logic                                   irq,
    input  wire logic [bcdalu_pkg::ADDR_W-1:0]     s_axi_awaddr,
    input  wire logic                              s_axi_awvalid,
    output logic                                   s_axi_awready,
    input  wire logic [31:0]                       s_axi_wdata,
    input  wire logic [3:0]                        s_axi_wstrb,
    input  wire logic                              s_axi_wvalid,
    output logic                                   s_axi_wready,
    output logic [1:0]                             s_axi_bresp,
    output logic                                   s_axi_bvalid,
    input  wire logic                              s_axi_bready,
    input  wire logic [bcdalu_pkg::ADDR_W-1:0]     s_axi_araddr,
    input  wire logic                              s_axi_arvalid,
    output logic                                   s_axi_arready,
    output logic [31:0]                            s_axi_rdata,
    output logic [1:0]                             s_axi_rresp,
    output logic                                   s_axi_rvalid,
    input  wire logic                              s_axi_rready
);
    bcdalu_pkg::bcdalu_state_t s_ff;
    bcdalu_pkg::bcdalu_state_t nxt_s;
    logic [1:0]                rst_sync_ff;

    logic [31:0] bcd_a;
    logic [31:0] bcd_b;
    logic [31:0] bcd_diff;
    logic [8:0]  bcd_brw;
    logic [31:0] bcd_prod;
    logic [7:0]  a_bad;
    logic [7:0]  b_bad;
    logic [31:0] real_res;
    logic        real_bad;
    logic        real_unf;
    logic        real_ovf;

    function automatic logic reg_hit(
        input logic [bcdalu_pkg::ADDR_W-1:0] addr,
        input logic [bcdalu_pkg::ADDR_W-1:0] ofs
    );
        // Only the aligned word address hits; the rest answer with an error
        return addr == ofs;
    endfunction

    function automatic logic addr_ok(
        input logic [bcdalu_pkg::ADDR_W-1:0] addr
    );
        return reg_hit(addr, bcdalu_pkg::OFS_ACC)
            || reg_hit(addr, bcdalu_pkg::OFS_FLAGS)
            || reg_hit(addr, bcdalu_pkg::OFS_STAT)
            || reg_hit(addr, bcdalu_pkg::OFS_MASK);
    endfunction

    function automatic logic [31:0] strb_merge(
        input logic [31:0] old,
        input logic [31:0] val,
        input logic [3:0]  strb
    );
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8+:8] = val[i*8+:8];
            end
        end
        return r;
    endfunction

    // 16-bit forms see zeroed upper digits so stray bits cannot leak in
    always_comb begin
        bcd_a = s_ff.acc;
        bcd_b = req.operand;
        if (req.op != bcdalu_pkg::OP_SUB32) begin
            bcd_a = {16'h0000, s_ff.acc[15:0]};
            bcd_b = {16'h0000, req.operand[15:0]};
        end
    end

    bcdalu_bcd_unit #(
        .DIGITS (bcdalu_pkg::DIGITS)
    ) u_bcd (
        .a      (bcd_a),
        .b      (bcd_b),
        .diff   (bcd_diff),
        .brw    (bcd_brw),
        .prod   (bcd_prod),
        .a_bad  (a_bad),
        .b_bad  (b_bad)
    );

    // Operands are trusted to be IEEE encoded by the sequencer
    bcdalu_fsub u_fsub (
        .a         (s_ff.acc),
        .b         (req.operand),
        .res       (real_res),
        .bad_float (real_bad),
        .underflow (real_unf),
        .overflow  (real_ovf)
    );

    always_comb begin
        logic        bad;
        logic [31:0] clr;
        bad = 1'b0;
        clr = '0;
        nxt_s = s_ff;
        nxt_s.done = 1'b0;

        // Address and data are taken independently, in either order
        if (s_axi_awvalid && s_ff.awready) begin
            nxt_s.aw_got = 1'b1;
            nxt_s.waddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_ff.wready) begin
            nxt_s.w_got = 1'b1;
            nxt_s.wdata = s_axi_wdata;
            nxt_s.wstrb = s_axi_wstrb;
        end
        if (s_ff.bvalid && s_axi_bready) begin
            nxt_s.bvalid = 1'b0;
        end
        if (s_ff.aw_got && s_ff.w_got && !s_ff.bvalid) begin
            nxt_s.aw_got = 1'b0;
            nxt_s.w_got = 1'b0;
            nxt_s.bvalid = 1'b1;
            nxt_s.bresp = addr_ok(s_ff.waddr) ? bcdalu_pkg::RESP_OKAY
                                              : bcdalu_pkg::RESP_SLVERR;
            if (reg_hit(s_ff.waddr, bcdalu_pkg::OFS_ACC)) begin
                nxt_s.acc = strb_merge(s_ff.acc, s_ff.wdata, s_ff.wstrb);
            end
            if (reg_hit(s_ff.waddr, bcdalu_pkg::OFS_STAT)) begin
                clr = strb_merge('0, s_ff.wdata, s_ff.wstrb);
            end
            if (reg_hit(s_ff.waddr, bcdalu_pkg::OFS_MASK)) begin
                nxt_s.mask = 10'(strb_merge(32'(s_ff.mask), s_ff.wdata,
                                            s_ff.wstrb));
            end
        end
        nxt_s.stat = s_ff.stat & ~clr[9:0];

        if (s_ff.rvalid && s_axi_rready) begin
            nxt_s.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_ff.arready) begin
            nxt_s.rvalid = 1'b1;
            nxt_s.rresp = bcdalu_pkg::RESP_OKAY;
            nxt_s.rdata = '0;
            if (reg_hit(s_axi_araddr, bcdalu_pkg::OFS_ACC)) begin
                nxt_s.rdata = s_ff.acc;
            end else if (reg_hit(s_axi_araddr, bcdalu_pkg::OFS_FLAGS)) begin
                nxt_s.rdata = 32'(s_ff.flags);
            end else if (reg_hit(s_axi_araddr, bcdalu_pkg::OFS_STAT)) begin
                nxt_s.rdata = 32'(s_ff.stat);
            end else if (reg_hit(s_axi_araddr, bcdalu_pkg::OFS_MASK)) begin
                nxt_s.rdata = 32'(s_ff.mask);
            end else begin
                nxt_s.rresp = bcdalu_pkg::RESP_SLVERR;
            end
        end

        // Operation after the bus so it wins a same-cycle write to ACC
        if (req.valid) begin
            nxt_s.done = 1'b1;
            unique case (req.op)
                bcdalu_pkg::OP_LOAD: begin
                    nxt_s.acc = req.operand;
                end
                bcdalu_pkg::OP_SUB16: begin
                    bad = |a_bad[3:0] | |b_bad[3:0];
                    if (!bad) begin
                        nxt_s.acc = {16'h0000, bcd_diff[15:0]};
                    end
                    nxt_s.flags.bad_bcd = bad;
                    nxt_s.flags.borrow_16 = !bad && bcd_brw[4];
                    nxt_s.flags.borrow_32 = 1'b0;
                    nxt_s.flags.negative = !bad && bcd_brw[4];
                    nxt_s.flags.zero_result = nxt_s.acc == '0;
                end
                bcdalu_pkg::OP_SUB32: begin
                    bad = |a_bad | |b_bad;
                    if (!bad) begin
                        nxt_s.acc = bcd_diff;
                    end
                    nxt_s.flags.bad_bcd = bad;
                    nxt_s.flags.borrow_16 = !bad && bcd_brw[4];
                    nxt_s.flags.borrow_32 = !bad && bcd_brw[8];
                    nxt_s.flags.negative = !bad && bcd_brw[8];
                    nxt_s.flags.zero_result = nxt_s.acc == '0;
                end
                bcdalu_pkg::OP_REAL_MINUS: begin
                    if (!req.ptr_bad) begin
                        nxt_s.acc = real_res;
                    end
                    nxt_s.flags.bad_pointer = req.ptr_bad;
                    nxt_s.flags.bad_float = req.ptr_bad
                        ? (s_ff.acc[30:23] == bcdalu_pkg::EXP_MAX)
                        : real_bad;
                    nxt_s.flags.sign_error = !req.ptr_bad
                                             && real_ovf;
                    nxt_s.flags.underflow = !req.ptr_bad
                                            && real_unf;
                    nxt_s.flags.zero_result = nxt_s.acc[30:0] == '0;
                    nxt_s.flags.negative = nxt_s.acc[31]
                        && !nxt_s.flags.zero_result
                        && !nxt_s.flags.bad_float;
                end
                bcdalu_pkg::OP_MUL16: begin
                    bad = |a_bad[3:0] | |b_bad[3:0];
                    if (!bad) begin
                        nxt_s.acc = bcd_prod;
                    end
                    nxt_s.flags.bad_bcd = bad;
                    nxt_s.flags.negative = 1'b0;
                    nxt_s.flags.zero_result = nxt_s.acc == '0;
                end
                default: begin
                    nxt_s.done = 1'b0;
                end
            endcase
            // Untouched flags fall through unchanged
        end

        // Set beats a same-cycle W1C so no event is lost
        if (nxt_s.done) begin
            nxt_s.stat = nxt_s.stat | {1'b1, nxt_s.flags};
        end
        nxt_s.irq = |(nxt_s.stat & nxt_s.mask);
        nxt_s.awready = !nxt_s.aw_got && !nxt_s.bvalid;
        nxt_s.wready = !nxt_s.w_got && !nxt_s.bvalid;
        nxt_s.arready = !nxt_s.rvalid;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync_ff <= 2'b00;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_ff[1]) begin
        if (!rst_sync_ff[1]) begin
            s_ff <= '{acc: bcdalu_pkg::ACC_RST, default: '0};
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign op_done       = s_ff.done;
    assign acc_out       = s_ff.acc;
    assign flags_out     = s_ff.flags;
    assign irq           = s_ff.irq;
    assign s_axi_awready = s_ff.awready;
    assign s_axi_wready  = s_ff.wready;
    assign s_axi_bvalid  = s_ff.bvalid;
    assign s_axi_bresp   = s_ff.bresp;
    assign s_axi_arready = s_ff.arready;
    assign s_axi_rvalid  = s_ff.rvalid;
    assign s_axi_rdata   = s_ff.rdata;
    assign s_axi_rresp   = s_ff.rresp;
endmodule

// ===== verif/bcdalu_checker.sv
// Concurrent checks on the request and result ports of the unit
module bcdalu_checker (
    input wire logic                      clk_sys,
    input wire logic                      rst_b,
    input wire bcdalu_pkg::bcdalu_req_t   req,
    input wire logic                      op_done,
    input wire logic [31:0]               acc_out,
    input wire bcdalu_pkg::bcdalu_flags_t flags_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic g16, g32, v16, v32;
    function automatic logic ok(input logic [31:0] v);
        ok = 1'b1;
        for (int i = 0; i < 8; i++)
            if (v[i*4 +: 4] > 4'h9)
                ok = 1'b0;
    endfunction
    assign g16 = req.valid && req.op == bcdalu_pkg::OP_SUB16;
    assign g32 = req.valid && req.op == bcdalu_pkg::OP_SUB32;
    // Borrow figures only mean something on decimal operands
    assign v16 = ok({16'h0, acc_out[15:0]})
                 && ok({16'h0, req.operand[15:0]});
    assign v32 = ok(acc_out) && ok(req.operand);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    done_after_req_a:
    assert property (req.valid && req.op inside {bcdalu_pkg::OP_LOAD,
        bcdalu_pkg::OP_SUB16, bcdalu_pkg::OP_SUB32, bcdalu_pkg::OP_REAL_MINUS,
        bcdalu_pkg::OP_MUL16} |=> op_done)
        else $error("no done pulse after a request");
    borrow16_a:
    assert property (g16 && v16 |=> flags_out.borrow_16 ==
        ($past(acc_out[15:0]) < $past(req.operand[15:0])))
        else $error("16-bit borrow wrong");
    borrow32_a:
    assert property (g32 && v32 |=> flags_out.borrow_32 ==
        ($past(acc_out) < $past(req.operand)))
        else $error("32-bit borrow wrong");
    neg_borrow_a:
    assert property (g16 && v16 |=> flags_out.negative == flags_out.borrow_16)
        else $error("negative differs from borrow");
    zero_flag_a:
    assert property ((g16 && v16) || (g32 && v32) |=>
        flags_out.zero_result == (acc_out == 32'h0))
        else $error("zero flag wrong");
    bad_digit_a:
    assert property (g16 |=> flags_out.bad_bcd == !$past(v16))
        else $error("non-decimal digit flag wrong");
    ptr_flag_a:
    assert property (req.valid && req.op == bcdalu_pkg::OP_REAL_MINUS |=>
        flags_out.bad_pointer == $past(req.ptr_bad))
        else $error("pointer flag wrong");
    load_keep_a:
    assert property (req.valid && req.op == bcdalu_pkg::OP_LOAD |=>
        $stable(flags_out))
        else $error("load disturbed the flags");
endmodule
bind bcdalu_top bcdalu_checker chk (.clk_sys, .rst_b, .req, .op_done,
    .acc_out, .flags_out);

// ===== verif/bcdalu_seq_model.sv
// Sequencer model: word memory, operand fetch and request issue
module bcdalu_seq_model (
    input  wire logic               clk_sys,
    output bcdalu_pkg::bcdalu_req_t req,
    input  wire logic               op_done
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] mem [16];
    initial req = '0;
    // Mode 0 constant, 1 direct word address, 2 through a pointer word
    task automatic issue(input bcdalu_pkg::bcdalu_op_t op,
                         input logic [1:0] md, input logic [31:0] k,
                         output logic seen);
        logic [15:0] a;
        a = (md == 2'h2) ? mem[k[3:0]] : k[15:0];
        @(posedge clk_sys);
        req.valid <= 1'b1;
        req.op <= op;
        // Real operands pass as raw IEEE words, never converted
        req.operand <= (md == 2'h0) ? k
                       : {mem[a[3:0] + 4'h1], mem[a[3:0]]};
        // A pointer past the word memory is flagged; only the real subtract then refuses its operand
        req.ptr_bad <= (md == 2'h2) && (a[15:4] != 12'h0);
        @(posedge clk_sys);
        req.valid <= 1'b0;
        // The released operand toggles so no stale word passes for a live one
        req.operand <= ~req.operand;
        for (int n = 0; n < 4 && op_done !== 1'b1; n++)
            @(negedge clk_sys);
        seen = op_done;
    endtask
endmodule

// ===== verif/test_bcd_real_sub_mul_alu.sv
// Testbench for the accumulator arithmetic unit
module test_bcd_real_sub_mul_alu;
    timeunit 1ns;
    timeprecision 1ns;
    localparam bcdalu_pkg::bcdalu_op_t LD = bcdalu_pkg::OP_LOAD,
        S16 = bcdalu_pkg::OP_SUB16, S32 = bcdalu_pkg::OP_SUB32,
        SR = bcdalu_pkg::OP_REAL_MINUS, MU = bcdalu_pkg::OP_MUL16;
    localparam logic [1:0] OK = bcdalu_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = bcdalu_pkg::RESP_SLVERR;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    bcdalu_pkg::bcdalu_req_t req;
    bcdalu_pkg::bcdalu_flags_t flags_out;
    logic op_done, irq, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [31:0] acc_out, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    int num_errors = 0;
    int checks = 0;
    always #50 clk_sys = ~clk_sys;
    bcdalu_top DUT (.clk_sys, .rst_b, .req, .op_done, .acc_out, .flags_out,
        .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    bcdalu_seq_model seq (.clk_sys, .req, .op_done);
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic run(input bcdalu_pkg::bcdalu_op_t op, input logic [1:0] md,
                       input logic [31:0] k, input logic [31:0] ex);
        logic seen;
        seq.issue(op, md, k, seen);
        chk(32'(seen), 32'h1);
        chk(acc_out, ex);
    endtask
    task automatic fl(input logic [8:0] m, input logic [8:0] v);
        chk(32'(flags_out & m), 32'(v));
    endtask
    task automatic axi_wr(input logic [3:0] ad, input logic [31:0] d,
                          input logic [1:0] er);
        @(posedge clk_sys);
        s_axi_awaddr <= ad;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        // No cycle count assumed: only the watchdog ends a stuck wait
        do begin
            @(posedge clk_sys);
            if (s_axi_awready === 1'b1)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1)
                s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk(32'(s_axi_bresp), 32'(er));
    endtask
    task automatic axi_rd(input logic [3:0] ad, input logic [31:0] ex,
                          input logic [1:0] er);
        @(posedge clk_sys);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready === 1'b1)
                s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, ex);
        chk(32'(s_axi_rresp), 32'(er));
    endtask
    task automatic irq_is(input logic v);
        repeat (2) @(negedge clk_sys);
        chk(32'(irq), 32'(v));
    endtask
    // Budget is generous: the whole run is about a hundred cycles
    initial begin
        #1000000;
        num_errors++;
        close_out();
    end
    initial begin
        seq.mem[0] = 16'h0235;
        seq.mem[1] = 16'h1000;
        seq.mem[2] = 16'h9999;
        seq.mem[3] = 16'h0999;
        seq.mem[4] = 16'h0005;
        seq.mem[5] = 16'h1234;
        seq.mem[6] = 16'h0020;
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk_sys);
        axi_wr(4'h0, 32'h1234, OK);
        run(S16, 2'h1, 32'h0, 32'h0999);
        fl(9'h00F, 9'h000);
        run(S16, 2'h1, 32'h1, 32'h9999);
        fl(9'h00F, 9'h00A);
        axi_rd(4'h4, 32'h00A, OK);
        $display("test bcd16 done");
        run(LD, 2'h0, 32'h10000000, 32'h10000000);
        run(S32, 2'h0, 32'h1, 32'h09999999);
        fl(9'h00F, 9'h002);
        run(S32, 2'h1, 32'h2, 32'h0);
        fl(9'h00F, 9'h001);
        run(S32, 2'h0, 32'h1, 32'h99999999);
        fl(9'h00F, 9'h00E);
        $display("test bcd32 done");
        run(LD, 2'h0, 32'h2, 32'h2);
        run(MU, 2'h2, 32'h4, 32'h2468);
        fl(9'h10F, 9'h006);
        run(LD, 2'h0, 32'h9999, 32'h9999);
        run(MU, 2'h0, 32'h9999, 32'h99980001);
        run(LD, 2'h0, 32'h12, 32'h12);
        run(S16, 2'h0, 32'hA0, 32'h12);
        fl(9'h100, 9'h100);
        run(MU, 2'h0, 32'h1, 32'h12);
        fl(9'h109, 9'h000);
        $display("test mul done");
        run(LD, 2'h0, 32'h40400000, 32'h40400000);
        run(SR, 2'h0, 32'h3F800000, 32'h40000000);
        fl(9'h009, 9'h000);
        run(SR, 2'h0, 32'h40400000, 32'hBF800000);
        fl(9'h00D, 9'h008);
        run(SR, 2'h2, 32'h6, 32'hBF800000);
        fl(9'h010, 9'h010);
        run(LD, 2'h0, 32'hFF7FFFFF, 32'hFF7FFFFF);
        run(SR, 2'h0, 32'h7F7FFFFF, 32'hFF800000);
        fl(9'h070, 9'h060);
        run(LD, 2'h0, 32'h00800001, 32'h00800001);
        run(SR, 2'h0, 32'h00800000, 32'h0);
        fl(9'h0E9, 9'h081);
        run(S16, 2'h0, 32'h0, 32'h0);
        fl(9'h081, 9'h081);
        $display("test real done");
        axi_wr(4'hC, 32'h200, OK);
        irq_is(1'b1);
        axi_wr(4'h8, 32'h3FF, OK);
        irq_is(1'b0);
        axi_rd(4'h8, 32'h0, OK);
        axi_rd(4'hC, 32'h200, OK);
        axi_wr(4'h2, 32'h1, ERR);
        axi_rd(4'h2, 32'h0, ERR);
        run(LD, 2'h0, 32'h5, 32'h5);
        axi_rd(4'h0, 32'h5, OK);
        irq_is(1'b1);
        $display("test irq done");
        close_out();
    end
endmodule
